// >>> hdl/phyeq_defines.svh
/*
  constants for the phy setting and equalizer adaptation block.
  assumes a 25 mhz core clock; included by bare name.
*/
`ifndef PHYEQ_DEFINES_SVH
`define PHYEQ_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PHYEQ_NPORT 4

// ----------------------------------------------------------------
// built-in defaults used without any preload
// ----------------------------------------------------------------
`define PHYEQ_DEF_SWING 4'h8
`define PHYEQ_DEF_DEEMPH 4'h0
`define PHYEQ_DEF_EQ 4'h2
`define PHYEQ_DEF_PWR_HIGH 1'b0

// ----------------------------------------------------------------
// equalizer gain and zero figures
// ----------------------------------------------------------------
`define PHYEQ_GAIN_MAX 4'hf
`define PHYEQ_GAIN_MIN 4'h0
`define PHYEQ_GAIN_MID 4'h8
`define PHYEQ_ZERO_MAX 3'h7
`define PHYEQ_ZERO_MIN 3'h0
`define PHYEQ_ZERO_RATE_LO 3'h2
`define PHYEQ_ZERO_RATE_HI 3'h5

// ----------------------------------------------------------------
// voting interval and threshold
// ----------------------------------------------------------------
`define PHYEQ_CLK_NS 40
`define PHYEQ_VOTE_NS 40000
`define PHYEQ_VOTE_CYC (`PHYEQ_VOTE_NS / `PHYEQ_CLK_NS)
`define PHYEQ_VOTE_THR 8'sd16
`define PHYEQ_ACC_MAX 8'sd127
`define PHYEQ_ACC_MIN -8'sd127

`endif

// >>> hdl/phyeq_pkg.sv
/*
  types shared by the phy setting and equalizer adaptation block.
  assumes nothing of its surroundings.
*/
package phyeq_pkg;

  // per-port settings as written by host or preload
  typedef struct packed {
    logic [3:0] swing;
    logic [3:0] tx_deemph_code;
    logic [3:0] rx_equalizer_code;
    logic removable;
    logic disable_port;
  } phyeq_port_cfg_t;

  // equalizer operating mode decoded from the code
  typedef enum logic [2:0] {
    PHYEQ_FLAT = 3'b000,
    PHYEQ_ADAPT_NORM = 3'b001,
    PHYEQ_ADAPT_REV = 3'b010,
    PHYEQ_HOLD = 3'b011,
    PHYEQ_INIT = 3'b100,
    PHYEQ_PARTIAL = 3'b101
  } phyeq_mode_t;

  // live equalizer setting of one receiver
  typedef struct packed {
    logic [3:0] gain;
    logic [2:0] zero;
  } phyeq_eq_state_t;

endpackage : phyeq_pkg

// >>> hdl/phyeq_tx_deemph.sv
/*
  one transmitter lane: picks the amplitude reduction for each bit.
  assumes bits arrive with a valid strobe in the core clock domain.
*/
`timescale 1ns/1ps
`include "phyeq_defines.svh"

module phyeq_tx_deemph (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // setting and bit stream
  input wire logic [3:0] deemph_code,
  input wire logic bit_valid,
  input wire logic bit_in,
  // reduction in tenths of a percent
  output logic [9:0] reduce_q
);

  logic prev_q;
  logic [9:0] table_w;
  logic repeat_w;

  // reduction grows with the code, none at zero
  assign table_w = (deemph_code == 4'h0) ? 10'd0 :
                   (deemph_code == 4'h1) ? 10'd53 :
                   (deemph_code == 4'h2) ? 10'd95 :
                   (deemph_code == 4'h3) ? 10'd138 :
                   (deemph_code == 4'h4) ? 10'd181 :
                   (deemph_code == 4'h5) ? 10'd225 :
                   (deemph_code == 4'h6) ? 10'd270 :
                   (deemph_code == 4'h7) ? 10'd314 :
                   (deemph_code == 4'h8) ? 10'd362 :
                   (deemph_code == 4'h9) ? 10'd408 :
                   (deemph_code == 4'ha) ? 10'd454 :
                   (deemph_code == 4'hb) ? 10'd502 :
                   (deemph_code == 4'hc) ? 10'd550 :
                   (deemph_code == 4'hd) ? 10'd597 :
                   (deemph_code == 4'he) ? 10'd645 : 10'd693;

  // a bit equal to its predecessor is reduced
  assign repeat_w = (bit_in == prev_q);

  // register previous bit and reduction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      reduce_q <= 10'd0;
    end else if (clk_en && bit_valid) begin
      prev_q <= bit_in;
      reduce_q <= repeat_w ? table_w : 10'd0;
    end
  end

endmodule : phyeq_tx_deemph

// >>> hdl/phyeq_vote.sv
/*
  voting accumulator for one receiver's gain decisions.
  assumes one observation per strobe in the core clock domain.
*/
`timescale 1ns/1ps
`include "phyeq_defines.svh"

module phyeq_vote (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // restart of voting
  input wire logic clear,
  // observations
  input wire logic obs_valid,
  input wire logic obs_more,
  // decision
  output logic dec_valid_q,
  output logic dec_more_q
);

  localparam logic [9:0] LAST = 10'(`PHYEQ_VOTE_CYC - 1);

  logic [9:0] cnt_q;
  logic signed [7:0] acc_q;
  logic signed [7:0] acc_d;
  logic end_w;

  // saturating vote tally
  assign acc_d = !obs_valid ? acc_q :
                 obs_more ? ((acc_q == `PHYEQ_ACC_MAX) ? acc_q : acc_q + 8'sd1) :
                 ((acc_q == `PHYEQ_ACC_MIN) ? acc_q : acc_q - 8'sd1);
  assign end_w = (cnt_q == LAST);

  // interval counter, tally and decision
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 10'd0;
      acc_q <= 8'sd0;
      dec_valid_q <= 1'b0;
      dec_more_q <= 1'b0;
    end else if (clk_en) begin
      if (clear) begin
        cnt_q <= 10'd0;
        acc_q <= 8'sd0;
        dec_valid_q <= 1'b0;
      end else if (end_w) begin
        cnt_q <= 10'd0;
        acc_q <= 8'sd0;
        dec_valid_q <= (acc_q >= `PHYEQ_VOTE_THR) || (acc_q <= -`PHYEQ_VOTE_THR);
        dec_more_q <= (acc_q > 8'sd0);
      end else begin
        cnt_q <= cnt_q + 10'd1;
        acc_q <= acc_d;
        dec_valid_q <= 1'b0;
      end
    end
  end

endmodule : phyeq_vote

// >>> hdl/phyeq_ctrl.sv
/*
  per-port phy setting control: transmit swing and de-emphasis,
  receive equalizer modes and adaptation, port power polarity.
  assumes host writes and preload writes arrive as one-cycle strobes
  in the core clock domain, and receive observations come from the
  receiver's pattern analyser as one strobe per observation.
*/
// Notes on behaviour
// - per-lane 4-bit swing, larger code larger swing
// - repeated bits reduced, post-transition bits full
// - de-emphasis code 0 none, up to 69.3 percent
// - equalizer code 0000 flat at maximum gain
// - code 0001 adapts, more eq lowers zero
// - code 0010 adapts, more eq raises zero
// - code 0011 freezes gain and zero
// - codes 01xx mid gain, rate-suited zero
// - codes 1xxx adapt gain, zero fixed 365-50MHz
// - gain raised or lowered from observed patterns
// - gain limit reached then zero steps
// - decisions voted over long interval
// - works from 24 or 48 MHz reference
// - built-in defaults without any preload
// - preload carries removable, disable, tx/rx settings
// - power enable active low unless preloaded
`timescale 1ns/1ps
`include "phyeq_defines.svh"

module phyeq_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // reference clock strap, high for 48 mhz
  input wire logic ref_48m_sel,
  // host settings write
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_port,
  input wire phyeq_pkg::phyeq_port_cfg_t cfg_data,
  // preload writes from the serial loader
  input wire logic pre_wr,
  input wire logic [1:0] pre_port,
  input wire phyeq_pkg::phyeq_port_cfg_t pre_data,
  input wire logic pre_pol_wr,
  input wire logic pre_pol_high,
  // port power requests
  input wire logic [`PHYEQ_NPORT-1:0] port_power_req,
  // transmit bit streams
  input wire logic [`PHYEQ_NPORT-1:0] tx_bit_valid,
  input wire logic [`PHYEQ_NPORT-1:0] tx_bit,
  // receive observations
  input wire logic [`PHYEQ_NPORT-1:0] rx_obs_valid,
  input wire logic [`PHYEQ_NPORT-1:0] rx_obs_more,
  input wire logic [`PHYEQ_NPORT-1:0] rx_rate_hi,
  // transmit settings out
  output logic [`PHYEQ_NPORT-1:0][3:0] tx_swing_q,
  output logic [`PHYEQ_NPORT-1:0][9:0] tx_reduce_q,
  // equalizer settings out
  output logic [`PHYEQ_NPORT-1:0][3:0] eq_gain_q,
  output logic [`PHYEQ_NPORT-1:0][2:0] eq_zero_q,
  // port status out
  output logic [`PHYEQ_NPORT-1:0] port_removable_q,
  output logic [`PHYEQ_NPORT-1:0] port_disabled_q,
  output logic [`PHYEQ_NPORT-1:0] port_power_enable_q,
  // reference clock divide select out
  output logic ref_div2_q
);

  // ----------------------------------------------------------------
  // reference strap capture
  // ----------------------------------------------------------------

  logic strap_done_q;

  // caught on first enabled edge after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
      ref_div2_q <= 1'b0;
    end else if (clk_en && !strap_done_q) begin
      strap_done_q <= 1'b1;
      ref_div2_q <= ref_48m_sel;
    end
  end

  // ----------------------------------------------------------------
  // power enable polarity
  // ----------------------------------------------------------------

  logic pol_high_q;

  // only the preload may flip the polarity
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_high_q <= `PHYEQ_DEF_PWR_HIGH;
    end else if (clk_en && pre_pol_wr) begin
      pol_high_q <= pre_pol_high;
    end
  end

  // ----------------------------------------------------------------
  // per-port lanes
  // ----------------------------------------------------------------

  genvar p;
  generate
    for (p = 0; p < `PHYEQ_NPORT; p = p + 1) begin : g_port

      phyeq_pkg::phyeq_port_cfg_t cfg_q;
      phyeq_pkg::phyeq_port_cfg_t cfg_d;
      phyeq_pkg::phyeq_eq_state_t st_q;
      phyeq_pkg::phyeq_eq_state_t st_d;
      phyeq_pkg::phyeq_mode_t mode_w;
      logic [3:0] eq_last_q;
      logic host_hit_w;
      logic pre_hit_w;
      logic [3:0] eq_w;
      logic code_chg_w;
      logic adapt_w;
      logic dec_valid_w;
      logic dec_more_w;
      logic at_min_w;
      logic at_max_w;
      logic [3:0] gain_dn_w;
      logic [3:0] gain_up_w;
      logic [2:0] zero_dn_w;
      logic [2:0] zero_up_w;
      logic [2:0] zero_init_w;
      logic [2:0] zero_fix_w;
      logic [3:0] gain_track_w;
      logic [2:0] zero_track_w;

      // --------------------------------
      // port settings
      // --------------------------------

      // write selection, preload wins a same-cycle clash
      assign host_hit_w = cfg_wr && (cfg_port == 2'(p));
      assign pre_hit_w = pre_wr && (pre_port == 2'(p));
      assign cfg_d = pre_hit_w ? pre_data : host_hit_w ? cfg_data : cfg_q;

      // settings register of this port only
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_q.swing <= `PHYEQ_DEF_SWING;
          cfg_q.tx_deemph_code <= `PHYEQ_DEF_DEEMPH;
          cfg_q.rx_equalizer_code <= `PHYEQ_DEF_EQ;
          cfg_q.removable <= 1'b1;
          cfg_q.disable_port <= 1'b0;
        end else if (clk_en) begin
          cfg_q <= cfg_d;
        end
      end

      // --------------------------------
      // equalizer mode
      // --------------------------------

      // mode decode from the equalizer code
      assign eq_w = cfg_q.rx_equalizer_code;
      assign mode_w = eq_w[3] ? phyeq_pkg::PHYEQ_PARTIAL :
                      eq_w[2] ? phyeq_pkg::PHYEQ_INIT :
                      (eq_w[1:0] == 2'b00) ? phyeq_pkg::PHYEQ_FLAT :
                      (eq_w[1:0] == 2'b01) ? phyeq_pkg::PHYEQ_ADAPT_NORM :
                      (eq_w[1:0] == 2'b10) ? phyeq_pkg::PHYEQ_ADAPT_REV :
                      phyeq_pkg::PHYEQ_HOLD;
      assign adapt_w = (mode_w == phyeq_pkg::PHYEQ_ADAPT_NORM) ||
                       (mode_w == phyeq_pkg::PHYEQ_ADAPT_REV) ||
                       (mode_w == phyeq_pkg::PHYEQ_PARTIAL);
      assign code_chg_w = (eq_w != eq_last_q);

      // --------------------------------
      // gain voting and tracking
      // --------------------------------

      // voting restarts whenever the code moves
      phyeq_vote u_vote (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .clear(!adapt_w || code_chg_w),
        .obs_valid(rx_obs_valid[p]),
        .obs_more(rx_obs_more[p]),
        .dec_valid_q(dec_valid_w),
        .dec_more_q(dec_more_w)
      );

      // saturating step helpers
      assign at_min_w = (st_q.gain == `PHYEQ_GAIN_MIN);
      assign at_max_w = (st_q.gain == `PHYEQ_GAIN_MAX);
      assign gain_dn_w = at_min_w ? st_q.gain : st_q.gain - 4'h1;
      assign gain_up_w = at_max_w ? st_q.gain : st_q.gain + 4'h1;
      assign zero_dn_w = (st_q.zero == `PHYEQ_ZERO_MIN) ? st_q.zero : st_q.zero - 3'h1;
      assign zero_up_w = (st_q.zero == `PHYEQ_ZERO_MAX) ? st_q.zero : st_q.zero + 3'h1;
      assign zero_init_w = rx_rate_hi[p] ? `PHYEQ_ZERO_RATE_HI : `PHYEQ_ZERO_RATE_LO;
      // code 1000 is the highest zero, 1111 the lowest
      assign zero_fix_w = ~eq_w[2:0];
      // more equalization means less low-frequency gain
      assign gain_track_w = !dec_valid_w ? st_q.gain :
                            dec_more_w ? gain_dn_w : gain_up_w;

      // zero motion once gain sits at a limit
      always_comb begin
        zero_track_w = st_q.zero;
        if (dec_valid_w && dec_more_w && at_min_w) begin
          if (mode_w == phyeq_pkg::PHYEQ_ADAPT_REV) begin
            zero_track_w = zero_up_w;
          end else begin
            zero_track_w = zero_dn_w;
          end
        end else if (dec_valid_w && !dec_more_w && at_max_w) begin
          if (mode_w == phyeq_pkg::PHYEQ_ADAPT_REV) begin
            zero_track_w = zero_dn_w;
          end else begin
            zero_track_w = zero_up_w;
          end
        end
      end

      // --------------------------------
      // equalizer state
      // --------------------------------

      // next equalizer state by mode
      always_comb begin
        st_d = st_q;
        case (mode_w)
          phyeq_pkg::PHYEQ_FLAT: begin
            st_d.gain = `PHYEQ_GAIN_MAX;
          end
          phyeq_pkg::PHYEQ_ADAPT_NORM,
          phyeq_pkg::PHYEQ_ADAPT_REV: begin
            st_d.gain = gain_track_w;
            st_d.zero = zero_track_w;
          end
          phyeq_pkg::PHYEQ_HOLD: begin
            st_d = st_q;
          end
          phyeq_pkg::PHYEQ_INIT: begin
            st_d.gain = `PHYEQ_GAIN_MID;
            st_d.zero = zero_init_w;
          end
          phyeq_pkg::PHYEQ_PARTIAL: begin
            st_d.gain = gain_track_w;
            st_d.zero = zero_fix_w;
          end
          default: begin
            st_d = st_q;
          end
        endcase
      end

      // equalizer state and last seen code
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          st_q.gain <= `PHYEQ_GAIN_MID;
          st_q.zero <= `PHYEQ_ZERO_RATE_LO;
          eq_last_q <= `PHYEQ_DEF_EQ;
        end else if (clk_en) begin
          st_q <= st_d;
          eq_last_q <= eq_w;
        end
      end

      assign eq_gain_q[p] = st_q.gain;
      assign eq_zero_q[p] = st_q.zero;

      // --------------------------------
      // transmit and status
      // --------------------------------

      // transmit reduction per bit
      phyeq_tx_deemph u_deemph (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .deemph_code(cfg_q.tx_deemph_code),
        .bit_valid(tx_bit_valid[p]),
        .bit_in(tx_bit[p]),
        .reduce_q(tx_reduce_q[p])
      );

      // status and power outputs
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tx_swing_q[p] <= `PHYEQ_DEF_SWING;
          port_removable_q[p] <= 1'b1;
          port_disabled_q[p] <= 1'b0;
          port_power_enable_q[p] <= !`PHYEQ_DEF_PWR_HIGH;
        end else if (clk_en) begin
          tx_swing_q[p] <= cfg_q.swing;
          port_removable_q[p] <= cfg_q.removable;
          port_disabled_q[p] <= cfg_q.disable_port;
          // drive level follows polarity; off when disabled
          port_power_enable_q[p] <=
            (port_power_req[p] && !cfg_q.disable_port) ~^ pol_high_q;
        end
      end

    end
  endgenerate

endmodule : phyeq_ctrl

// >>> dv/phyeq_ctrl_sva.sv
/*
  checker for phyeq_ctrl, bound to its ports.
  assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "phyeq_defines.svh"

module phyeq_ctrl_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // writes
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_port,
  input wire phyeq_pkg::phyeq_port_cfg_t cfg_data,
  input wire logic pre_wr,
  input wire logic [1:0] pre_port,
  input wire phyeq_pkg::phyeq_port_cfg_t pre_data,
  input wire logic pre_pol_wr,
  input wire logic pre_pol_high,
  // lanes
  input wire logic [`PHYEQ_NPORT-1:0] port_power_req,
  input wire logic [`PHYEQ_NPORT-1:0] tx_bit_valid,
  input wire logic [`PHYEQ_NPORT-1:0] tx_bit,
  // outputs
  input wire logic [`PHYEQ_NPORT-1:0][3:0] tx_swing_q,
  input wire logic [`PHYEQ_NPORT-1:0][9:0] tx_reduce_q,
  input wire logic [`PHYEQ_NPORT-1:0][3:0] eq_gain_q,
  input wire logic [`PHYEQ_NPORT-1:0][2:0] eq_zero_q,
  input wire logic [`PHYEQ_NPORT-1:0] port_power_enable_q
);
  // ----------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------
  logic [`PHYEQ_NPORT-1:0][3:0] code_q;
  logic pol_q;
  logic prev_q;
  logic [3:0] g2_q;
  logic [11:0] cnt_q;
  logic hwr;

  // host write not overridden by a preload to the same port
  assign hwr = clk_en && cfg_wr && !(pre_wr && pre_port == cfg_port);

  // equalizer codes, polarity, last lane-0 bit, cycles since gain move
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      code_q <= {`PHYEQ_NPORT{`PHYEQ_DEF_EQ}};
      pol_q <= `PHYEQ_DEF_PWR_HIGH;
      prev_q <= 1'b0;
      g2_q <= `PHYEQ_GAIN_MID;
      cnt_q <= 12'h000;
    end else if (clk_en) begin
      if (hwr) code_q[cfg_port] <= cfg_data.rx_equalizer_code;
      if (pre_wr) code_q[pre_port] <= pre_data.rx_equalizer_code;
      if (pre_pol_wr) pol_q <= pre_pol_high;
      if (tx_bit_valid[0]) prev_q <= tx_bit[0];
      g2_q <= eq_gain_q[2];
      if (cfg_wr || pre_wr || eq_gain_q[2] != g2_q) cnt_q <= 12'h000;
      else if (cnt_q != 12'hfff) cnt_q <= cnt_q + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence host_wr_s;
    hwr ##1 clk_en;
  endsequence

  sequence norm_code_s;
    code_q[2] == 4'h1 && $past(code_q[2]) == 4'h1;
  endsequence

  swing_follow_a: assert property (
    host_wr_s |=> tx_swing_q[$past(cfg_port, 2)] == $past(cfg_data.swing, 2))
    else $error("swing output does not follow host write");
  flat_gain_a: assert property (
    hwr && cfg_data.rx_equalizer_code == 4'h0 |-> ##2
    eq_gain_q[$past(cfg_port, 2)] == `PHYEQ_GAIN_MAX)
    else $error("flat code did not give maximum gain");
  init_mid_a: assert property (
    hwr && cfg_data.rx_equalizer_code[3:2] == 2'b01 |-> ##2
    eq_gain_q[$past(cfg_port, 2)] == `PHYEQ_GAIN_MID)
    else $error("initialize code did not give mid gain");
  partial_zero_a: assert property (
    code_q[2][3] && $stable(code_q[2]) |-> eq_zero_q[2] == ~code_q[2][2:0])
    else $error("partial mode zero position wrong");
  hold_frozen_a: assert property (
    code_q[3] == 4'h3 && $past(code_q[3]) == 4'h3 |->
    $stable(eq_gain_q[3]) && $stable(eq_zero_q[3]))
    else $error("equalizer moved while held");
  norm_step_a: assert property (
    norm_code_s and $changed(eq_zero_q[2]) |->
    ($past(eq_gain_q[2]) == 4'h0 && eq_zero_q[2] == $past(eq_zero_q[2]) - 3'h1) ||
    ($past(eq_gain_q[2]) == 4'hf && eq_zero_q[2] == $past(eq_zero_q[2]) + 3'h1))
    else $error("normal tracking zero step wrong");
  rev_step_a: assert property (
    code_q[3] == 4'h2 && $past(code_q[3]) == 4'h2 && $changed(eq_zero_q[3]) |->
    ($past(eq_gain_q[3]) == 4'h0 && eq_zero_q[3] == $past(eq_zero_q[3]) + 3'h1) ||
    ($past(eq_gain_q[3]) == 4'hf && eq_zero_q[3] == $past(eq_zero_q[3]) - 3'h1))
    else $error("reversed tracking zero step wrong");
  vote_slow_a: assert property (
    code_q[2] == 4'h1 && $changed(eq_gain_q[2]) |-> cnt_q < 12'h003 || cnt_q >= 12'h010)
    else $error("gain moved on too few observations");
  tx_edge_a: assert property (
    clk_en && tx_bit_valid[0] && tx_bit[0] != prev_q |=> tx_reduce_q[0] == 10'h000)
    else $error("bit after transition was reduced");
  power_pol_a: assert property (
    clk_en && !port_power_req[0] && !pre_pol_wr |=> port_power_enable_q[0] == !pol_q)
    else $error("idle power pin level wrong");
endmodule : phyeq_ctrl_sva

bind phyeq_ctrl phyeq_ctrl_sva chk_u (.clk, .rst_b, .clk_en, .cfg_wr, .cfg_port, .cfg_data,
  .pre_wr, .pre_port, .pre_data, .pre_pol_wr, .pre_pol_high, .port_power_req, .tx_bit_valid,
  .tx_bit, .tx_swing_q, .tx_reduce_q, .eq_gain_q, .eq_zero_q, .port_power_enable_q);

// >>> dv/phyeq_link_model.sv
/*
  link partner model: feeds receive observations to each port.
  assumes the bench picks which ports talk, their loss and pace.
*/
`timescale 1ns/1ps
`include "phyeq_defines.svh"

module phyeq_link_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // behaviour chosen by the bench
  input wire logic [`PHYEQ_NPORT-1:0] talk,
  input wire logic [`PHYEQ_NPORT-1:0] lossy,
  input wire logic slow,
  // observations toward the receivers
  output logic [`PHYEQ_NPORT-1:0] rx_obs_valid,
  output logic [`PHYEQ_NPORT-1:0] rx_obs_more
);
  logic tick;

  // one observation a cycle, or every other one when slow; idle line toggles
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick = 1'b0;
      rx_obs_valid = '0;
      rx_obs_more = '0;
    end else begin
      tick = !tick;
      rx_obs_valid = talk & {`PHYEQ_NPORT{tick || !slow}};
      rx_obs_more = (rx_obs_valid & lossy) | (~rx_obs_valid & ~rx_obs_more);
    end
  end
endmodule : phyeq_link_model

// >>> dv/phyeq_ctrl_test.sv
/*
  bench for phyeq_ctrl: host and preload writes, tx bits, link model.
  assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
`include "phyeq_defines.svh"

module phyeq_ctrl_test;
  localparam int N = `PHYEQ_NPORT;
  logic clk, rst_b, cfg_wr, pre_wr, pre_pol_wr, pre_pol_high, ref_div2_q, slow;
  logic [1:0] cfg_port, pre_port;
  phyeq_pkg::phyeq_port_cfg_t cfg_data, pre_data;
  logic [N-1:0] port_power_req, tx_bit_valid, tx_bit, rx_obs_valid, rx_obs_more, rx_rate_hi;
  logic [N-1:0] talk, lossy, port_removable_q, port_disabled_q, port_power_enable_q;
  logic [N-1:0][3:0] tx_swing_q, eq_gain_q;
  logic [N-1:0][9:0] tx_reduce_q;
  logic [N-1:0][2:0] eq_zero_q;
  logic [3:0] g3;
  logic [2:0] z3;
  logic clk_en, ref_48m_sel;
  logic [3:0] dcode [4] = '{4'h0, 4'h3, 4'h8, 4'hf};
  logic [9:0] dred [4] = '{10'h000, 10'h08a, 10'h16a, 10'h2b5};
  int n_fail, compares;

  phyeq_ctrl dut_u (.clk, .rst_b, .clk_en, .ref_48m_sel, .cfg_wr, .cfg_port,
    .cfg_data, .pre_wr, .pre_port, .pre_data, .pre_pol_wr, .pre_pol_high, .port_power_req,
    .tx_bit_valid, .tx_bit, .rx_obs_valid, .rx_obs_more, .rx_rate_hi, .tx_swing_q,
    .tx_reduce_q, .eq_gain_q, .eq_zero_q, .port_removable_q, .port_disabled_q,
    .port_power_enable_q, .ref_div2_q);
  phyeq_link_model link_u (.clk, .rst_b, .talk, .lossy, .slow, .rx_obs_valid, .rx_obs_more);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // 40 ns core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  function automatic phyeq_pkg::phyeq_port_cfg_t mk(logic [3:0] s, d, e, logic r, x);
    mk = {s, d, e, r, x};
  endfunction : mk

  // one write pulse from host and/or preload
  task automatic wr(logic h, logic p, logic [1:0] pt, phyeq_pkg::phyeq_port_cfg_t d);
    @(negedge clk);
    {cfg_wr, pre_wr, cfg_port, pre_port, cfg_data, pre_data} = {h, p, pt, pt, d, d};
    @(negedge clk);
    {cfg_wr, pre_wr} = 2'b00;
    cyc(2);
  endtask : wr

  // one lane-0 bit, then its reduction
  task automatic txb(logic b, logic [9:0] exp);
    @(negedge clk);
    {tx_bit_valid[0], tx_bit[0]} = {1'b1, b};
    @(negedge clk);
    tx_bit_valid[0] = 1'b0;
    cyc(1);
    check(tx_reduce_q[0], exp);
  endtask : txb

  // bounded wait for a gain or zero to leave a value
  task automatic wait_ne(logic [1:0] p, logic z, logic [3:0] v);
    int i;
    for (i = 0; i < 12000 && (z ? {1'b0, eq_zero_q[p]} : eq_gain_q[p]) === v; i++) cyc(1);
    check(i < 12000, 1'b1);
  endtask : wait_ne

  task give_verdict;
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // main sequence
  initial begin
    {rst_b, cfg_wr, pre_wr, pre_pol_wr, pre_pol_high, slow} = '0;
    {cfg_port, pre_port, port_power_req, tx_bit_valid, tx_bit, rx_rate_hi, talk, lossy} = '0;
    cfg_data = mk(4'h8, 4'h0, 4'h2, 1'b1, 1'b0);
    pre_data = cfg_data;
    {clk_en, ref_48m_sel} = 2'b11;
    n_fail = 0;
    compares = 0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    cyc(2);
    for (int k = 0; k < N; k++)
      check({tx_swing_q[k], eq_gain_q[k], eq_zero_q[k], tx_reduce_q[k]}, 21'h110800);
    check({port_removable_q, port_disabled_q, port_power_enable_q, ref_div2_q}, 13'h1e1f);
    for (int s = 0; s < 16; s++) begin
      wr(1'b1, 1'b0, 2'h0, mk(s[3:0], 4'h0, 4'h2, 1'b1, 1'b0));
      check({tx_swing_q[0], tx_swing_q[1]}, {s[3:0], 4'h8});
    end
    foreach (dcode[i]) begin
      wr(1'b1, 1'b0, 2'h0, mk(4'h8, dcode[i], 4'h2, 1'b1, 1'b0));
      txb(1'b1, 10'h000);
      txb(1'b1, dred[i]);
      txb(1'b0, 10'h000);
      txb(1'b0, dred[i]);
    end
    wr(1'b1, 1'b0, 2'h1, mk(4'h8, 4'h0, 4'h0, 1'b1, 1'b0));
    check({eq_gain_q[1], eq_gain_q[0]}, 8'hf8);
    wr(1'b1, 1'b0, 2'h1, mk(4'h8, 4'h0, 4'h4, 1'b1, 1'b0));
    check({eq_gain_q[1], eq_zero_q[1]}, 7'h42);
    rx_rate_hi[1] = 1'b1;
    wr(1'b1, 1'b0, 2'h1, mk(4'h8, 4'h0, 4'h7, 1'b1, 1'b0));
    check({eq_gain_q[1], eq_zero_q[1]}, 7'h45);
    for (int c = 8; c < 16; c++) begin
      wr(1'b1, 1'b0, 2'h1, mk(4'h8, 4'h0, c[3:0], 1'b1, 1'b0));
      check({eq_gain_q[1], eq_zero_q[1]}, {4'h8, 3'h7 - c[2:0]});
    end
    wr(1'b1, 1'b0, 2'h2, mk(4'h8, 4'h0, 4'h1, 1'b1, 1'b0));
    wr(1'b1, 1'b0, 2'h3, mk(4'h8, 4'h0, 4'h2, 1'b1, 1'b0));
    {talk, lossy} = 8'hcc;
    wait_ne(2'h2, 1'b1, 4'h2);
    check({eq_gain_q[2], eq_zero_q[2]}, 7'h01);
    wait_ne(2'h3, 1'b1, 4'h2);
    check({eq_gain_q[3], eq_zero_q[3]}, 7'h03);
    {talk, lossy} = 8'h00;
    wr(1'b1, 1'b0, 2'h3, mk(4'h8, 4'h0, 4'h3, 1'b1, 1'b0));
    {g3, z3} = {eq_gain_q[3], eq_zero_q[3]};
    wr(1'b1, 1'b0, 2'h2, mk(4'h8, 4'h0, 4'h8, 1'b1, 1'b0));
    {talk, lossy, slow} = {4'hc, 4'h0, 1'b1};
    wait_ne(2'h2, 1'b0, eq_gain_q[2]);
    check({eq_gain_q[2], eq_zero_q[2]}, 7'h0f);
    cyc(1000);
    check({eq_gain_q[3], eq_zero_q[3]}, {g3, z3});
    {talk, slow} = '0;
    port_power_req = 4'hf;
    cyc(2);
    check(port_power_enable_q, 4'h0);
    @(negedge clk);
    {cfg_wr, pre_wr, cfg_port, pre_port} = 6'h35;
    {cfg_data, pre_data} = {mk(4'h3, 4'h0, 4'h2, 1'b1, 1'b0), mk(4'h5, 4'h0, 4'h2, 1'b0, 1'b1)};
    @(negedge clk);
    {cfg_wr, pre_wr, pre_pol_wr, pre_pol_high} = 4'b0011;
    @(negedge clk);
    pre_pol_wr = 1'b0;
    cyc(3);
    check({tx_swing_q[1], port_removable_q, port_disabled_q, port_power_enable_q}, 16'h5d2d);
    // a write is lost while frozen; then a second reset with a 24 mhz strap
    clk_en = 1'b0;
    wr(1'b1, 1'b0, 2'h0, mk(4'h1, 4'h0, 4'h2, 1'b1, 1'b0));
    check(tx_swing_q[0], 4'h8);
    {clk_en, rst_b, ref_48m_sel} = 3'b100;
    cyc(2);
    rst_b = 1'b1;
    cyc(2);
    check({ref_div2_q, tx_swing_q[0], eq_gain_q[2]}, 9'h088);
    give_verdict;
  end

  // cut a hang well beyond the expected span
  initial begin
    #2000000;
    n_fail++;
    give_verdict;
  end
endmodule : phyeq_ctrl_test
